//--- css_pkg.sv
package css_pkg;
	localparam int CLK_HZ          = 100_000_000;
	localparam int TICK_NS         = 100_000_000;
	localparam int CLK_NS          = 10;
	localparam int TICK_CYCLES     = TICK_NS / CLK_NS;
	localparam int SLOTS           = 4;
	localparam logic [9:0]  SHOTS_MAX   = 10'h3e7;
	localparam logic [15:0] WAIT_MIN    = 16'h0005;
	localparam logic [15:0] TIME_MAX    = 16'hea5f;
	localparam logic [15:0] EXP_MIN     = 16'h0001;
	localparam logic [15:0] FIRST_WAIT  = 16'h000a;
	localparam logic [15:0] FOCUS_LEAD  = 16'h0003;
	localparam logic [15:0] PAUSE_AT    = 16'h0001;
	localparam logic [15:0] LOCK_MAX    = 16'h00c8;
	localparam logic [15:0] LOCK_PULSE  = 16'h0002;
	localparam logic [15:0] LOCK_MIN    = 16'h0005;
	localparam logic [9:0]  DONE_RST    = 10'h000;
	localparam logic [1:0]  SLOT_RST    = 2'h0;

	typedef enum logic [1:0] {
		CSS_MODE_UNUSED = 2'b00,
		CSS_MODE_SINGLE = 2'b01,
		CSS_MODE_ALL    = 2'b10
	} css_mode_t;

	typedef enum logic [2:0] {
		CSS_IDLE   = 3'b000,
		CSS_WAIT   = 3'b001,
		CSS_DITHER = 3'b010,
		CSS_PAUSED = 3'b011,
		CSS_LOCK   = 3'b100,
		CSS_EXPO   = 3'b101,
		CSS_NEXT   = 3'b110,
		CSS_EXTT   = 3'b111
	} css_state_t;

	localparam logic [1:0] PH_WAIT = 2'h0;
	localparam logic [1:0] PH_LOCK = 2'h1;
	localparam logic [1:0] PH_EXPO = 2'h2;
	localparam logic [1:0] PH_NONE = 2'h3;
	localparam logic [1:0] LN_NONE  = 2'h0;
	localparam logic [1:0] LN_FOCUS = 2'h1;
	localparam logic [1:0] LN_BOTH  = 2'h2;
endpackage

//--- camera_shutter_sequencer.sv
`timescale 1ns/1ps
// Function
// - take exactly shot count exposures, 1..999
// - wait at least programmed wait, dithering stretches
// - first wait after start is one second
// - focus line on in last 0.3 s
// - lockup 0 to 20 s, zero disables
// - lockup pulses shutter 0.2 s, then idle
// - enabled lockup lasts at least 0.5 s
// - exposure line held for exposure time
// - stop aborts any phase, lines released
// - pause latched, holds at last 0.1 s
// - continue clears pause, lockup or exposure starts immediately
// - parameter writes only while paused or idle
// - report phase and line state
// - remaining seconds reported, rounded upward
// - four slots with own settings and mode
// - single slot start runs only that slot
// - modes all, single, unused govern advance
// - advance increments slot, wraps four to one
// - multi run clears counters, ends when done
// - active slot locked, modes changeable while running
// - external timer mode uses active slot only
// - dither request each inter-exposure wait, before pause
// - hold wait until position settled
// - external timer shutter on only while dithering
module css_camera_shutter_sequencer
	import css_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start_single,
	input  wire logic        start_multi,
	input  wire logic        stop_cmd,
	input  wire logic        pause_cmd,
	input  wire logic        continue_cmd,
	input  wire logic        ext_timer_mode,
	input  wire logic        dither_enable,
	input  wire logic        position_settled,
	input  wire logic [1:0]  sel_slot,
	input  wire logic        sel_slot_we,
	input  wire logic [1:0]  wr_slot,
	input  wire logic        wr_params,
	input  wire logic [9:0]  wr_shots,
	input  wire logic [15:0] wr_wait,
	input  wire logic [15:0] wr_lock,
	input  wire logic [15:0] wr_expo,
	input  wire logic        wr_mode_we,
	input  wire logic [1:0]  wr_mode,
	output logic             focus_out,
	output logic             focus_oe_n,
	output logic             expo_out,
	output logic             expo_oe_n,
	output logic             dither_request,
	output logic             running,
	output logic             paused,
	output logic             pause_pending,
	output logic             wr_refused,
	output logic [1:0]       phase,
	output logic [1:0]       line_state,
	output logic [11:0]      remain_sec,
	output logic [1:0]       active_slot,
	output logic [9:0]       shot_index
);
	initial begin
		if (TICK_DIV < 1) $error("tick divider too small");
		if (FOCUS_LEAD >= WAIT_MIN) $error("focus lead longer than shortest wait");
		if (LOCK_PULSE >= LOCK_MIN) $error("lockup pulse leaves no idle part");
	end

	logic [9:0]  shots_reg [SLOTS];
	logic [15:0] wait_reg  [SLOTS];
	logic [15:0] lock_reg  [SLOTS];
	logic [15:0] expo_reg  [SLOTS];
	css_mode_t   mode_reg  [SLOTS];
	logic [9:0]  done_reg  [SLOTS];

	css_state_t  state_reg;
	css_state_t  state_next;
	logic [31:0] div_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic [1:0]  slot_reg;
	logic [1:0]  slot_next;
	logic [2:0]  visit_reg;
	logic [2:0]  visit_next;
	logic        multi_reg;
	logic        first_reg;
	logic        pend_reg;
	logic        dreq_reg;
	logic        focus_reg;
	logic        expo_reg_o;
	logic        dith_go;

	// out of range settings are clamped rather than refused
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [11:0] ceil_sec(input logic [15:0] t);
		logic [15:0] s;
		s = (t + 16'h0009) / 16'h000a;
		ceil_sec = s[11:0];
	endfunction

	function automatic logic [1:0] phase_of(input css_state_t st);
		case (st)
			CSS_WAIT, CSS_DITHER, CSS_PAUSED: phase_of = PH_WAIT;
			CSS_LOCK: phase_of = PH_LOCK;
			CSS_EXPO, CSS_EXTT: phase_of = PH_EXPO;
			default: phase_of = PH_NONE;
		endcase
	endfunction

	wire tick = (div_reg == 32'(TICK_DIV - 1));
	wire is_run = (state_reg != CSS_IDLE);
	wire wr_ok = !is_run || (state_reg == CSS_PAUSED);
	wire [1:0] slot_inc = slot_reg + 2'h1;
	wire [9:0] cur_shots = (shots_reg[slot_reg] == 10'h000) ? 10'h001 :
		((shots_reg[slot_reg] > SHOTS_MAX) ? SHOTS_MAX : shots_reg[slot_reg]);
	wire slot_done = (done_reg[slot_reg] >= cur_shots);
	wire slot_usable = !slot_done && (mode_reg[slot_reg] != CSS_MODE_UNUSED);
	wire [15:0] wait_ld = first_reg ? FIRST_WAIT :
		clamp(wait_reg[slot_reg], WAIT_MIN, TIME_MAX);
	wire [15:0] lock_ld = clamp(lock_reg[slot_reg], LOCK_MIN, LOCK_MAX);
	// raw value tested, so only an exact zero disables lockup
	wire lock_on = (lock_reg[slot_reg] != 16'h0000);
	wire [15:0] expo_ld = clamp(expo_reg[slot_reg], EXP_MIN, TIME_MAX);
	wire cnt_end = tick && (cnt_reg <= 16'h0001);
	wire        start_any   = start_single || start_multi;
	wire        idle_start  = (state_reg == CSS_IDLE) && start_any;
	wire        at_pause    = tick && (cnt_reg == PAUSE_AT);
	wire        dith_due    = at_pause && dither_enable && !first_reg && !dreq_reg;
	wire [15:0] after_wait  = lock_on ? lock_ld : expo_ld;
	// divider parked so the phase after a hold gets a whole first tick
	wire        hold_div    = (state_reg == CSS_PAUSED) || (state_reg == CSS_DITHER);
	wire        ext_settled = (state_reg == CSS_DITHER) && position_settled && ext_timer_mode;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		slot_next = slot_reg;
		visit_next = visit_reg;
		dith_go = 1'b0;
		case (state_reg)
			CSS_IDLE: begin
				if (ext_timer_mode && start_any) begin
					state_next = CSS_EXTT;
					cnt_next = expo_ld;
				end else if (start_multi) begin
					// start slot is judged like any other, an unused one is skipped
					state_next = CSS_NEXT;
					visit_next = 3'h1;
				end else if (start_single) begin
					state_next = CSS_WAIT;
					cnt_next = FIRST_WAIT;
				end
			end
			CSS_WAIT: begin
				if (dith_due) begin
					state_next = CSS_DITHER;
					dith_go = 1'b1;
				end else if (at_pause && pend_reg) begin
					state_next = CSS_PAUSED;
				end else if (cnt_end) begin
					state_next = lock_on ? CSS_LOCK : CSS_EXPO;
					cnt_next = after_wait;
				end else if (tick) begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			CSS_DITHER: begin
				if (position_settled) begin
					state_next = pend_reg ? CSS_PAUSED : CSS_WAIT;
					cnt_next = PAUSE_AT;
				end
			end
			CSS_PAUSED: begin
				if (continue_cmd) begin
					state_next = lock_on ? CSS_LOCK : CSS_EXPO;
					cnt_next = after_wait;
				end
			end
			CSS_LOCK: begin
				if (cnt_end) begin
					state_next = CSS_EXPO;
					cnt_next = expo_ld;
				end else if (tick) begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			CSS_EXPO: begin
				if (cnt_end) begin
					state_next = CSS_NEXT;
					visit_next = 3'h0;
				end else if (tick) begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			CSS_NEXT: begin
				// one slot examined per cycle keeps the decode small
				if (!multi_reg) begin
					state_next = slot_done ? CSS_IDLE : CSS_WAIT;
					cnt_next = wait_ld;
				end else if (slot_usable && visit_reg != 3'h0) begin
					state_next = CSS_WAIT;
					cnt_next = wait_ld;
				end else if (slot_usable && mode_reg[slot_reg] == CSS_MODE_ALL) begin
					state_next = CSS_WAIT;
					cnt_next = wait_ld;
				end else if (visit_reg == 3'h4) begin
					state_next = CSS_IDLE;
				end else begin
					slot_next = slot_inc;
					visit_next = visit_reg + 3'h1;
				end
			end
			CSS_EXTT: begin
				if (cnt_end) begin
					state_next = CSS_DITHER;
					dith_go = 1'b1;
				end else if (tick) begin
					cnt_next = cnt_reg - 16'h0001;
				end
			end
			default: state_next = CSS_IDLE;
		endcase
		// external timer loops back to its count after every settle
		if (ext_settled) begin
			state_next = CSS_EXTT;
			cnt_next = expo_ld;
		end
		if (!multi_reg && state_reg == CSS_NEXT) slot_next = slot_reg;
		if (stop_cmd) state_next = CSS_IDLE;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 32'h0;
		end else if (tick || !is_run || hold_div) begin
			div_reg <= 32'h0;
		end else begin
			div_reg <= div_reg + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= CSS_IDLE;
			cnt_reg <= 16'h0;
			slot_reg <= SLOT_RST;
			visit_reg <= 3'h0;
			multi_reg <= 1'b0;
			first_reg <= 1'b0;
			pend_reg <= 1'b0;
			dreq_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			slot_reg <= slot_next;
			visit_reg <= visit_next;
			if (state_reg == CSS_IDLE && sel_slot_we) slot_reg <= sel_slot;
			if (state_reg == CSS_IDLE && start_multi && !ext_timer_mode) multi_reg <= 1'b1;
			else if (state_reg == CSS_IDLE && start_single) multi_reg <= 1'b0;
			if (state_reg == CSS_IDLE) first_reg <= 1'b1;
			else if (state_reg == CSS_EXPO) first_reg <= 1'b0;
			if (state_next == CSS_IDLE || continue_cmd) pend_reg <= 1'b0;
			else if (pause_cmd && is_run) pend_reg <= 1'b1;
			// one move per wait; the exposure rearms it
			if (state_reg == CSS_EXPO) dreq_reg <= 1'b0;
			else if (dith_go) dreq_reg <= 1'b1;
		end
	end

	for (genvar i = 0; i < SLOTS; i++) begin : g_slot
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				shots_reg[i] <= 10'h001;
				wait_reg[i] <= WAIT_MIN;
				lock_reg[i] <= 16'h0000;
				expo_reg[i] <= EXP_MIN;
				mode_reg[i] <= CSS_MODE_UNUSED;
				done_reg[i] <= DONE_RST;
			end else begin
				if (wr_params && wr_ok && wr_slot == 2'(i)) begin
					shots_reg[i] <= wr_shots;
					wait_reg[i] <= wr_wait;
					lock_reg[i] <= wr_lock;
					expo_reg[i] <= wr_expo;
				end
				if (wr_mode_we && wr_slot == 2'(i)) mode_reg[i] <= css_mode_t'(wr_mode);
				if (idle_start) begin
					done_reg[i] <= DONE_RST;
				end else if (state_reg == CSS_EXPO && cnt_end && slot_reg == 2'(i)) begin
					done_reg[i] <= done_reg[i] + 10'h001;
				end
			end
		end
	end

	wire lock_pulse = (state_reg == CSS_LOCK) &&
		((lock_ld - cnt_reg) < LOCK_PULSE);
	wire focus_win = ((state_reg == CSS_WAIT) || (state_reg == CSS_DITHER) ||
		(state_reg == CSS_PAUSED)) && (cnt_reg <= FOCUS_LEAD);
	wire shutter_on = lock_pulse || (state_reg == CSS_EXPO) ||
		(ext_timer_mode && state_reg == CSS_DITHER);
	// stop gates the next value so both lines drop on the stop edge
	wire focus_d = !stop_cmd && (focus_win || shutter_on);
	wire expo_d = !stop_cmd && shutter_on;
	wire [11:0] remain_d = (state_reg == CSS_PAUSED || state_reg == CSS_DITHER) ? 12'h001 :
		ceil_sec(cnt_reg);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			focus_reg <= 1'b0;
			expo_reg_o <= 1'b0;
			phase <= PH_NONE;
			remain_sec <= 12'h0;
			wr_refused <= 1'b0;
		end else begin
			focus_reg <= focus_d;
			expo_reg_o <= expo_d;
			wr_refused <= wr_params && !wr_ok;
			phase <= phase_of(state_reg);
			remain_sec <= remain_d;
		end
	end

	assign focus_out      = focus_reg;
	assign focus_oe_n     = !focus_reg;
	assign expo_out       = expo_reg_o;
	assign expo_oe_n      = !expo_reg_o;
	assign dither_request = (state_reg == CSS_DITHER);
	assign running        = is_run;
	assign paused         = (state_reg == CSS_PAUSED);
	assign pause_pending  = pend_reg;
	assign line_state     = expo_reg_o ? LN_BOTH : (focus_reg ? LN_FOCUS : LN_NONE);
	assign active_slot    = slot_reg;
	assign shot_index     = done_reg[slot_reg];
endmodule // css_camera_shutter_sequencer

//--- css_chk.sv
`timescale 1ns/1ps
module css_chk
	import css_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        start_single,
	input wire logic        start_multi,
	input wire logic        stop_cmd,
	input wire logic        ext_timer_mode,
	input wire logic        wr_params,
	input wire logic        focus_out,
	input wire logic        expo_out,
	input wire logic        dither_request,
	input wire logic        running,
	input wire logic        paused,
	input wire logic        wr_refused,
	input wire logic [1:0]  phase,
	input wire logic [1:0]  line_state,
	input wire logic [11:0] remain_sec
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence s_released;
		!focus_out && !expo_out && !running;
	endsequence
	sequence s_lock_idle;
		(!focus_out && !expo_out)[*8];
	endsequence
	property p_stop;
		stop_cmd |=> s_released;
	endproperty
	property p_refuse;
		wr_params |=> wr_refused == $past(running && !paused);
	endproperty
	property p_start;
		start_single && !start_multi && !stop_cmd && !running && !ext_timer_mode |=>
			running ##1 phase == PH_WAIT;
	endproperty
	property p_lead;
		$rose(expo_out) && $past(phase) == PH_WAIT |-> $past(focus_out);
	endproperty
	property p_lock_pulse;
		phase == PH_LOCK && $fell(expo_out) |=> s_lock_idle;
	endproperty
	property p_expo;
		phase == PH_EXPO && running && !ext_timer_mode |-> expo_out && focus_out;
	endproperty
	property p_both;
		expo_out |-> focus_out && line_state == LN_BOTH;
	endproperty
	property p_state;
		line_state == (expo_out ? LN_BOTH : (focus_out ? LN_FOCUS : LN_NONE));
	endproperty
	property p_pause;
		paused |-> remain_sec == 12'h001;
	endproperty
	property p_dither;
		dither_request && !ext_timer_mode |-> !expo_out;
	endproperty
	a_stop: assert property (p_stop) else $error("lines held after stop");
	a_refuse: assert property (p_refuse) else $error("write refusal wrong");
	a_start: assert property (p_start) else $error("start not in wait");
	a_lead: assert property (p_lead) else $error("no focus before exposure");
	a_lock_pulse: assert property (p_lock_pulse) else $error("lockup idle broken");
	a_expo: assert property (p_expo) else $error("exposure lines off");
	a_both: assert property (p_both) else $error("exposure without focus");
	a_state: assert property (p_state) else $error("line state wrong");
	a_pause: assert property (p_pause) else $error("paused remain not one");
	a_dither: assert property (p_dither) else $error("exposure while dithering");
endmodule // css_chk
bind css_camera_shutter_sequencer css_chk css_chk_i (.clk, .rst_n, .start_single, .start_multi,
	.stop_cmd,
	.ext_timer_mode, .wr_params, .focus_out, .expo_out, .dither_request, .running, .paused,
	.wr_refused, .phase, .line_state, .remain_sec);

//--- css_camera_model.sv
`timescale 1ns/1ps
// camera shutter input: counts low pulses on the exposure line, in cycles
module css_camera_model (
	input wire logic clk,
	input wire logic focus_line,
	input wire logic expo_line
);
	int pulses = 0;
	int len    = 0;
	int gap    = 0;
	int lead   = 0;
	int run    = 0;
	int idle   = 0;
	int fcnt   = 0;
	always @(posedge clk) begin
		if (!expo_line) begin
			if (run == 0) begin
				pulses++;
				gap  = idle;
				lead = fcnt;
			end
			run++;
			len  = run;
			idle = 0;
		end else begin
			run = 0;
			idle++;
		end
		fcnt = (!focus_line && expo_line) ? fcnt + 1 : 0;
	end
endmodule // css_camera_model

//--- css_camera_shutter_sequencer_test.sv
`timescale 1ns/1ps
module css_camera_shutter_sequencer_test;
	import css_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start_single = 1'b0, start_multi = 1'b0, stop_cmd = 1'b0, pause_cmd = 1'b0;
	logic continue_cmd = 1'b0, ext_timer_mode = 1'b0, dither_enable = 1'b0;
	logic position_settled = 1'b0, sel_slot_we = 1'b0, wr_params = 1'b0, wr_mode_we = 1'b0;
	logic [1:0] sel_slot = 2'h0, wr_slot = 2'h0, wr_mode = 2'h0;
	logic [9:0] wr_shots = 10'h001;
	logic [15:0] wr_wait = 16'h0005, wr_lock = 16'h0000, wr_expo = 16'h0001;
	logic focus_out, focus_oe_n, expo_out, expo_oe_n, dither_request, running, paused;
	logic pause_pending, wr_refused;
	logic [1:0] phase, line_state, active_slot;
	logic [11:0] remain_sec;
	logic [9:0] shot_index;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	// open collector lines with pull-up: low only while driven
	wire focus_line = focus_oe_n ? 1'b1 : 1'b0;
	wire expo_line = expo_oe_n ? 1'b1 : 1'b0;
	// short timebase: one tick is ten cycles
	css_camera_shutter_sequencer #(.TICK_DIV(10)) css_camera_shutter_sequencer_i (.clk, .rst_n,
		.start_single, .start_multi, .stop_cmd, .pause_cmd, .continue_cmd, .ext_timer_mode,
		.dither_enable, .position_settled, .sel_slot, .sel_slot_we, .wr_slot, .wr_params,
		.wr_shots, .wr_wait, .wr_lock, .wr_expo, .wr_mode_we, .wr_mode, .focus_out, .focus_oe_n,
		.expo_out, .expo_oe_n, .dither_request, .running, .paused, .pause_pending, .wr_refused,
		.phase, .line_state, .remain_sec, .active_slot, .shot_index);
	css_camera_model cam (.clk, .focus_line, .expo_line);
	always #5 clk = ~clk;
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (ok !== 1'b1) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse(ref logic sig);
		sig = 1'b1;
		step();
		sig = 1'b0;
	endtask
	// bounded: a stuck design still reaches the report
	task automatic wait_for(ref logic sig, input logic val);
		int n;
		n = 0;
		while (sig !== val && n < 5000) begin
			step();
			n++;
		end
		chk(n < 5000, n, 5000);
	endtask
	task automatic wr(input logic [1:0] s, input logic [9:0] n, input logic [15:0] l,
		input logic [15:0] e, input logic [1:0] m);
		wr_slot = s;
		wr_shots = n;
		wr_lock = l;
		wr_expo = e;
		wr_mode = m;
		wr_mode_we = 1'b1;
		pulse(wr_params);
		wr_mode_we = 1'b0;
		step();
	endtask
	task automatic t_single();
		int p, n;
		p = cam.pulses;
		n = 0;
		wr(2'h0, 10'h002, 16'h0000, 16'h0002, CSS_MODE_UNUSED);
		pulse(start_single);
		while (cam.pulses == p && n < 500) begin
			step();
			n++;
		end
		chk(n >= 97 && n <= 103, n, 100);
		chk(cam.lead >= 28 && cam.lead <= 32, cam.lead, 30);
		wait_for(running, 1'b0);
		chk(cam.pulses - p == 2 && cam.len >= 19 && cam.len <= 21, cam.pulses - p, 2);
		chk(active_slot === 2'h0, active_slot, 0);
		$display("test single done");
	endtask
	task automatic t_lock();
		int p;
		p = cam.pulses;
		wr(2'h0, 10'h001, 16'h0003, 16'h0002, CSS_MODE_UNUSED);
		pulse(start_single);
		wait_for(expo_out, 1'b1);
		wait_for(expo_out, 1'b0);
		chk(cam.len >= 19 && cam.len <= 21, cam.len, 20);
		wait_for(running, 1'b0);
		chk(cam.pulses - p == 2 && cam.gap >= 28 && cam.gap <= 32, cam.gap, 30);
		$display("test lockup done");
	endtask
	task automatic t_stop();
		wr(2'h0, 10'h003, 16'h0000, 16'h0014, CSS_MODE_UNUSED);
		pulse(start_single);
		pulse(wr_params);
		chk(wr_refused === 1'b1, wr_refused, 1);
		wait_for(expo_out, 1'b1);
		pulse(stop_cmd);
		chk(!focus_out && !expo_out && !running && line_state === LN_NONE, line_state, 0);
		$display("test stop done");
	endtask
	task automatic t_multi();
		int p;
		p = cam.pulses;
		wr(2'h0, 10'h002, 16'h0000, 16'h0001, CSS_MODE_SINGLE);
		wr(2'h1, 10'h001, 16'h0000, 16'h0001, CSS_MODE_ALL);
		wr(2'h2, 10'h001, 16'h0000, 16'h0001, CSS_MODE_UNUSED);
		wr(2'h3, 10'h001, 16'h0000, 16'h0001, CSS_MODE_UNUSED);
		pulse(sel_slot_we);
		pulse(start_multi);
		pulse(pause_cmd);
		wait_for(paused, 1'b1);
		chk(remain_sec === 12'h001, remain_sec, 1);
		pulse(wr_params);
		chk(wr_refused === 1'b0, wr_refused, 0);
		pulse(continue_cmd);
		step(3);
		chk(paused === 1'b0 && phase === PH_EXPO, phase, PH_EXPO);
		wait_for(running, 1'b0);
		chk(cam.pulses - p == 3, cam.pulses - p, 3);
		$display("test multi done");
	endtask
	task automatic t_dither();
		int p, q;
		p = cam.pulses;
		dither_enable = 1'b1;
		wr(2'h0, 10'h002, 16'h0000, 16'h0001, CSS_MODE_UNUSED);
		pulse(start_single);
		wait_for(dither_request, 1'b1);
		q = cam.pulses;
		step(40);
		chk(cam.pulses == q && dither_request === 1'b1, cam.pulses, q);
		pulse(position_settled);
		wait_for(running, 1'b0);
		chk(cam.pulses - p == 2, cam.pulses - p, 2);
		dither_enable = 1'b0;
		$display("test dither done");
	endtask
	task automatic t_ext();
		int p;
		p = cam.pulses;
		wr(2'h0, 10'h001, 16'h0000, 16'h0003, CSS_MODE_UNUSED);
		ext_timer_mode = 1'b1;
		pulse(start_multi);
		wait_for(dither_request, 1'b1);
		step(2);
		chk(cam.pulses - p == 1 && expo_out === 1'b1 && active_slot === 2'h0, cam.pulses - p, 1);
		pulse(position_settled);
		step(2);
		chk(expo_out === 1'b0 && running === 1'b1, expo_out, 0);
		pulse(stop_cmd);
		ext_timer_mode = 1'b0;
		$display("test external timer done");
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// whole run needs about a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			stop_test();
		end
	end
	initial begin
		step(6);
		rst_n = 1'b1;
		t_single();
		t_lock();
		t_stop();
		t_multi();
		t_dither();
		t_ext();
		stop_test();
	end
endmodule // css_camera_shutter_sequencer_test
